// file: common/tx_defs.svh
// Shared offsets, field positions, reset values and timing counts.
`ifndef TX_DEFS_SVH
`define TX_DEFS_SVH
// ----------------------------------------
// Device register offsets on the link
// ----------------------------------------
`define OFS_CMD 5'h00
`define OFS_TSTAT 5'h03
`define OFS_TPAGE 5'h04
`define OFS_TCNT_L 5'h05
`define OFS_TCNT_H 5'h06
`define OFS_NCOL 5'h07
`define OFS_RSTART_L 5'h08
`define OFS_RSTART_H 5'h09
`define OFS_RCNT_L 5'h0a
`define OFS_RCNT_H 5'h0b
`define OFS_RING_EN 5'h0d
`define OFS_WCFG 5'h0e
`define OFS_DATA 5'h10
`define OFS_QEN 5'h1b
`define OFS_TEPR 5'h1c
`define OFS_RING_FIRST 5'h1d
`define OFS_RING_LAST 5'h1e
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define CMD_TXREQ_BIT 2
`define TSTAT_DONE_BIT 0
`define TSTAT_COL_BIT 2
`define TSTAT_ABT_BIT 3
`define TEPR_FULL_BIT 7
`define TXQ_DEPTH 3'h4
`define MIN_PAYLOAD 16'h003c
`define PREAMBLE_BYTE 8'h55
`define SFD_BYTE 8'hd5
`define CRC_INIT 32'hffff_ffff
`define CRC_POLY 32'hedb8_8320
`define MAX_RETRY 4'hf
`define RING_FIRST_RST 8'h40
`define RING_LAST_RST 8'h45
// ----------------------------------------
// Host APB register offsets
// ----------------------------------------
`define APB_ADDR 12'h000
`define APB_WDATA 12'h004
`define APB_GO 12'h008
`define APB_STAT 12'h00c
`define APB_RDATA 12'h010
// ----------------------------------------
// Timing
// ----------------------------------------
`define PCLK_PERIOD_NS 40
`define IPG_NS 9600
`define SLOT_NS 51200
`define IPG_CYC ((`IPG_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define SLOT_CYC ((`SLOT_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`endif

// file: common/tx_pkg.sv
// Types shared by both ends of the transmit link.
package tx_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_WAIT = 3'b001,
    TX_SEND = 3'b010
  } tx_state_t;
  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_REQ = 1'b1
  } host_state_t;
endpackage : tx_pkg

// file: common/tx_link_if.sv
// Register and data port link between host controller and device.
`timescale 1ns/100ps
interface tx_link_if;
  logic req;
  logic wr;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface : tx_link_if

// file: hw/tx_device.sv
// Device end: registers, remote write engine, transmit queue and serial sender.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "tx_defs.svh"
// How it works
// - Remote writes run on past buffer end.
// - Host keeps transmit data off receive area.
// - Ring enable wraps last page to first.
// - Transmit request pushes page and count entry.
// - After each packet, pop and send next.
// - End page report updated per packet.
// - Count excludes preamble and CRC; device adds.
// - Short frames padded to 64 bytes.
// - Port transfer is word or byte by mode.
// - Host programs page and counts before request.
// - Request clears status, starts prefetch.
// - Start needs gap, FIFO byte, backoff done.
// - Collision resets FIFO, pointers, counts it.
// - Fifteen failed retries abort with flag.
// - Word mode: even byte low, odd high.
// - Byte mode: bytes consecutive in order.
// - Buffer order on wire, LSB first.
// - Start and count register pairs steer DMA.
// - Store in sequence, step address and count.
// - Remote write ends at count zero.
// - Port handshake paces every transfer.
module tx_device (
  input wire logic pclk,
  input wire logic presetn,
  tx_link_if.dev link,
  input wire logic collision_in,
  output logic tx_en,
  output logic tx_data
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic ack_q;
  logic [15:0] rdata_q;
  logic [7:0] command_reg;
  logic [7:0] tx_page_start;
  logic [15:0] tx_count;
  logic [15:0] remote_addr;
  logic [15:0] remote_count;
  logic ring_en;
  logic word_transfer_select;
  logic queue_en;
  logic [7:0] ring_first;
  logic [7:0] ring_last;
  logic [7:0] tx_status_reg;
  logic [7:0] collision_count_reg;
  logic [7:0] end_page;
  logic [15:0] mem [0:8191];
  logic [7:0] q_page [0:3];
  logic [15:0] q_cnt [0:3];
  logic [1:0] q_wr;
  logic [1:0] q_rd;
  logic [2:0] q_count;
  logic col_s1;
  logic col_s2;
  tx_pkg::tx_state_t state;
  logic [7:0] cur_page;
  logic [15:0] cur_count;
  logic [15:0] cur_len;
  logic [15:0] fptr;
  logic [15:0] fcount;
  logic [7:0] fifo_byte;
  logic fifo_valid;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic [15:0] pos;
  logic cur_is_data;
  logic in_crc;
  logic [31:0] crc;
  logic [4:0] crc_cnt;
  logic [3:0] retry_cnt;
  logic [11:0] backoff_cnt;
  logic [11:0] ipg_cnt;

  // ----------------------------------------
  // Link decode
  // ----------------------------------------
  // A request is taken once; ack blocks a second take of the same one.
  wire accept = link.req & ~ack_q;
  wire wr_hit = accept & link.wr;
  wire [7:0] wbyte = link.wdata[7:0];
  wire w_cmd = wr_hit & (link.addr == `OFS_CMD);
  wire txreq_write = w_cmd & link.wdata[`CMD_TXREQ_BIT];
  wire q_full = (q_count == `TXQ_DEPTH);
  wire q_empty = (q_count == 3'h0);
  wire push = txreq_write & (queue_en ? ~q_full : (q_empty & (state == tx_pkg::TX_IDLE)));
  wire pop = (state == tx_pkg::TX_IDLE) & ~q_empty;
  wire data_write = wr_hit & (link.addr == `OFS_DATA) & (remote_count != 16'h0000);

  // ----------------------------------------
  // Remote write address stepping
  // ----------------------------------------
  // step by mode
  wire [15:0] step = word_transfer_select ? 16'h0002 : 16'h0001;
  wire [15:0] raddr_inc = remote_addr + step;
  wire ring_cross = ring_en & (remote_addr[15:8] == ring_last) & (raddr_inc[15:8] != ring_last);
  wire [15:0] next_remote_addr = ring_cross ? {ring_first, 8'h00} : raddr_inc;
  wire [15:0] next_remote_count = (remote_count > step) ? remote_count - step : 16'h0000;

  // ----------------------------------------
  // Transmit events
  // ----------------------------------------
  wire sending = (state == tx_pkg::TX_SEND);
  wire coll_evt = sending & col_s2;
  wire abort_evt = coll_evt & (retry_cnt == `MAX_RETRY);
  wire done_evt = sending & ~col_s2 & in_crc & (crc_cnt == 5'h1f);
  wire start_ok = (state == tx_pkg::TX_WAIT) & (ipg_cnt == 12'h000) & fifo_valid & (backoff_cnt == 12'h000);
  wire [15:0] total = cur_len + 16'h0008;
  wire [15:0] mem_word = mem[fptr[13:1]];
  wire [7:0] mem_byte = fptr[0] ? mem_word[15:8] : mem_word[7:0];
  wire [15:0] last_addr = {cur_page, 8'h00} + cur_count - 16'h0001;
  wire [7:0] byte_src = (pos < 16'h0007) ? `PREAMBLE_BYTE : (pos == 16'h0007) ? `SFD_BYTE : fifo_byte;
  wire crc_fb = crc[0] ^ shreg[0];
  wire [31:0] crc_next = {1'b0, crc[31:1]} ^ (crc_fb ? `CRC_POLY : 32'h0000_0000);
  wire [7:0] status_set = {4'h0, abort_evt, coll_evt, 1'b0, done_evt};
  // request clears status; a same-cycle set still wins
  wire [7:0] next_tx_status = (txreq_write ? 8'h00 : tx_status_reg) | status_set;
  wire [2:0] next_q_count = q_count + {2'b00, push} - {2'b00, pop};

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] rd_byte =
    (link.addr == `OFS_CMD) ? {command_reg[7:3], ~q_empty | (state != tx_pkg::TX_IDLE), command_reg[1:0]} :
    (link.addr == `OFS_TSTAT) ? tx_status_reg :
    (link.addr == `OFS_TPAGE) ? tx_page_start :
    (link.addr == `OFS_TCNT_L) ? tx_count[7:0] :
    (link.addr == `OFS_TCNT_H) ? tx_count[15:8] :
    (link.addr == `OFS_NCOL) ? collision_count_reg :
    (link.addr == `OFS_RSTART_L) ? remote_addr[7:0] :
    (link.addr == `OFS_RSTART_H) ? remote_addr[15:8] :
    (link.addr == `OFS_RCNT_L) ? remote_count[7:0] :
    (link.addr == `OFS_RCNT_H) ? remote_count[15:8] :
    (link.addr == `OFS_RING_EN) ? {7'h00, ring_en} :
    (link.addr == `OFS_WCFG) ? {7'h00, word_transfer_select} :
    (link.addr == `OFS_QEN) ? {7'h00, queue_en} :
    (link.addr == `OFS_TEPR) ? {q_full, end_page[6:0]} :
    (link.addr == `OFS_RING_FIRST) ? ring_first :
    (link.addr == `OFS_RING_LAST) ? ring_last : 8'h00;

  assign link.ack = ack_q;
  assign link.rdata = rdata_q;

  // Collision pin comes from the line, so it is synchronised first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_s1 <= 1'b0;
      col_s2 <= 1'b0;
    end else begin
      col_s1 <= collision_in;
      col_s2 <= col_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= accept;
      if (accept & ~link.wr) begin
        rdata_q <= {8'h00, rd_byte};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_reg <= 8'h00;
      tx_page_start <= 8'h00;
      tx_count <= 16'h0000;
      ring_en <= 1'b0;
      word_transfer_select <= 1'b0;
      queue_en <= 1'b0;
      ring_first <= `RING_FIRST_RST;
      ring_last <= `RING_LAST_RST;
    end else if (wr_hit) begin
      case (link.addr)
        `OFS_CMD: command_reg <= wbyte;
        `OFS_TPAGE: tx_page_start <= wbyte;
        `OFS_TCNT_L: tx_count[7:0] <= wbyte;
        `OFS_TCNT_H: tx_count[15:8] <= wbyte;
        `OFS_RING_EN: ring_en <= wbyte[0];
        `OFS_WCFG: word_transfer_select <= wbyte[0];
        `OFS_QEN: queue_en <= wbyte[0];
        `OFS_RING_FIRST: ring_first <= wbyte;
        `OFS_RING_LAST: ring_last <= wbyte;
        default: command_reg <= command_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_addr <= 16'h0000;
      remote_count <= 16'h0000;
    end else if (data_write) begin
      remote_addr <= next_remote_addr;
      remote_count <= next_remote_count;
    end else if (wr_hit) begin
      case (link.addr)
        `OFS_RSTART_L: remote_addr[7:0] <= wbyte;
        `OFS_RSTART_H: remote_addr[15:8] <= wbyte;
        `OFS_RCNT_L: remote_count[7:0] <= wbyte;
        `OFS_RCNT_H: remote_count[15:8] <= wbyte;
        default: remote_addr <= remote_addr;
      endcase
    end
  end

  // Packet memory; storage only, so it carries no reset.
  // word or byte lane
  always_ff @(posedge pclk) begin
    if (data_write) begin
      if (word_transfer_select) begin
        mem[remote_addr[13:1]] <= link.wdata;
      end else if (remote_addr[0]) begin
        mem[remote_addr[13:1]][15:8] <= wbyte;
      end else begin
        mem[remote_addr[13:1]][7:0] <= wbyte;
      end
    end
  end

  // Command queue entries; no reset needed, pointers guard them.
  always_ff @(posedge pclk) begin
    if (push) begin
      q_page[q_wr] <= tx_page_start;
      q_cnt[q_wr] <= tx_count;
    end
  end

  // Queue pointers, status and collision counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_wr <= 2'b00;
      q_rd <= 2'b00;
      q_count <= 3'h0;
      tx_status_reg <= 8'h00;
      collision_count_reg <= 8'h00;
      end_page <= 8'h00;
    end else begin
      q_wr <= q_wr + {1'b0, push};
      q_rd <= q_rd + {1'b0, pop};
      q_count <= next_q_count;
      tx_status_reg <= next_tx_status;
      collision_count_reg <= collision_count_reg + {7'h00, coll_evt};
      if (done_evt) begin
        end_page <= last_addr[15:8];
      end
    end
  end

  // Transmit sequencer: prefetch, gap and backoff wait, serial send.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tx_pkg::TX_IDLE;
      cur_page <= 8'h00;
      cur_count <= 16'h0000;
      cur_len <= 16'h0000;
      fptr <= 16'h0000;
      fcount <= 16'h0000;
      fifo_byte <= 8'h00;
      fifo_valid <= 1'b0;
      shreg <= 8'h00;
      bit_cnt <= 3'h0;
      pos <= 16'h0000;
      cur_is_data <= 1'b0;
      in_crc <= 1'b0;
      crc <= `CRC_INIT;
      crc_cnt <= 5'h00;
      retry_cnt <= 4'h0;
      backoff_cnt <= 12'h000;
      ipg_cnt <= 12'h000;
      tx_en <= 1'b0;
      tx_data <= 1'b0;
    end else begin
      if (ipg_cnt != 12'h000) begin
        ipg_cnt <= ipg_cnt - 12'h001;
      end
      if (backoff_cnt != 12'h000) begin
        backoff_cnt <= backoff_cnt - 12'h001;
      end
      // prefetch into FIFO; bytes past the count are pad zeros
      if ((state != tx_pkg::TX_IDLE) & ~fifo_valid & (fcount < cur_len)) begin
        fifo_byte <= (fcount < cur_count) ? mem_byte : 8'h00;
        fifo_valid <= 1'b1;
        fptr <= fptr + 16'h0001;
        fcount <= fcount + 16'h0001;
      end
      case (state)
        tx_pkg::TX_IDLE: begin
          tx_en <= 1'b0;
          if (pop) begin
            cur_page <= q_page[q_rd];
            cur_count <= q_cnt[q_rd];
            cur_len <= (q_cnt[q_rd] < `MIN_PAYLOAD) ? `MIN_PAYLOAD : q_cnt[q_rd];
            fptr <= {q_page[q_rd], 8'h00};
            fcount <= 16'h0000;
            fifo_valid <= 1'b0;
            retry_cnt <= 4'h0;
            state <= tx_pkg::TX_WAIT;
          end
        end
        tx_pkg::TX_WAIT: begin
          if (start_ok) begin
            shreg <= `PREAMBLE_BYTE;
            pos <= 16'h0001;
            bit_cnt <= 3'h0;
            cur_is_data <= 1'b0;
            in_crc <= 1'b0;
            crc <= `CRC_INIT;
            crc_cnt <= 5'h00;
            state <= tx_pkg::TX_SEND;
          end
        end
        tx_pkg::TX_SEND: begin
          if (coll_evt) begin
            tx_en <= 1'b0;
            fifo_valid <= 1'b0;
            fptr <= {cur_page, 8'h00};
            fcount <= 16'h0000;
            ipg_cnt <= 12'(`IPG_CYC);
            backoff_cnt <= 12'(`SLOT_CYC);
            retry_cnt <= retry_cnt + 4'h1;
            state <= abort_evt ? tx_pkg::TX_IDLE : tx_pkg::TX_WAIT;
          end else if (in_crc) begin
            tx_en <= 1'b1;
            tx_data <= ~crc[0];
            crc <= {1'b1, crc[31:1]};
            crc_cnt <= crc_cnt + 5'h01;
            if (done_evt) begin
              ipg_cnt <= 12'(`IPG_CYC);
              state <= tx_pkg::TX_IDLE;
            end
          end else begin
            tx_en <= 1'b1;
            tx_data <= shreg[0];
            if (cur_is_data) begin
              crc <= crc_next;
            end
            if (bit_cnt == 3'h7) begin
              if (pos == total) begin
                in_crc <= 1'b1;
              end else begin
                shreg <= byte_src;
                cur_is_data <= (pos >= 16'h0008);
                pos <= pos + 16'h0001;
                if (pos >= 16'h0008) begin
                  fifo_valid <= 1'b0;
                end
              end
              bit_cnt <= 3'h0;
            end else begin
              shreg <= {1'b0, shreg[7:1]};
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        default: state <= tx_pkg::TX_IDLE;
      endcase
    end
  end
endmodule : tx_device

// file: hw/tx_host.sv
// Host end: APB slave registers that drive transfers on the device link.
`timescale 1ns/100ps
`include "tx_defs.svh"
module tx_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tx_link_if.host link
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  tx_pkg::host_state_t state;
  logic [4:0] tgt_addr;
  logic [15:0] tgt_wdata;
  logic [15:0] tgt_rdata;
  logic tgt_wr;
  logic byte_mode;
  logic req_q;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire mapped = (paddr == `APB_ADDR) | (paddr == `APB_WDATA) | (paddr == `APB_GO) |
    (paddr == `APB_STAT) | (paddr == `APB_RDATA);
  wire wr_acc = access & pwrite & mapped;
  // A go while busy is dropped; software polls busy first.
  wire go = wr_acc & (paddr == `APB_GO) & (state == tx_pkg::H_IDLE);
  wire busy = (state == tx_pkg::H_REQ);
  wire [31:0] rd_mux =
    (paddr == `APB_ADDR) ? {27'h000_0000, tgt_addr} :
    (paddr == `APB_WDATA) ? {16'h0000, tgt_wdata} :
    (paddr == `APB_STAT) ? {30'h0000_0000, byte_mode, busy} :
    (paddr == `APB_RDATA) ? {16'h0000, tgt_rdata} : 32'h0000_0000;
  // byte mode uses low lane only
  wire [15:0] drive_data = byte_mode ? {8'h00, tgt_wdata[7:0]} : tgt_wdata;

  // Zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign link.req = req_q;
  assign link.wr = tgt_wr;
  assign link.addr = tgt_addr;
  assign link.wdata = drive_data;

  // Read data is captured in setup so it stands through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  // Software registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_addr <= 5'h00;
      tgt_wdata <= 16'h0000;
    end else if (wr_acc & ~busy) begin
      if (paddr == `APB_ADDR) begin
        tgt_addr <= pwdata[4:0];
      end
      if (paddr == `APB_WDATA) begin
        tgt_wdata <= pwdata[15:0];
      end
    end
  end

  // Link sequencer: hold the request until the device acks it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tx_pkg::H_IDLE;
      req_q <= 1'b0;
      tgt_wr <= 1'b0;
      tgt_rdata <= 16'h0000;
      byte_mode <= 1'b1;
    end else begin
      case (state)
        tx_pkg::H_IDLE: begin
          if (go) begin
            req_q <= 1'b1;
            tgt_wr <= pwdata[0];
            state <= tx_pkg::H_REQ;
          end
        end
        tx_pkg::H_REQ: begin
          if (link.ack) begin
            req_q <= 1'b0;
            state <= tx_pkg::H_IDLE;
            if (!tgt_wr) begin
              tgt_rdata <= link.rdata;
            end
            // Shadow the width select so data writes match the device.
            if (tgt_wr & (tgt_addr == `OFS_WCFG)) begin
              byte_mode <= ~tgt_wdata[0];
            end
          end
        end
        default: state <= tx_pkg::H_IDLE;
      endcase
    end
  end
endmodule : tx_host

// file: tb/tx_link_assertions.sv
// Checker for the host-to-device link and the serial frame output.
`timescale 1ns/100ps
module tx_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic collision_in,
  input wire logic tx_en,
  input wire logic tx_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned on_cnt;
  int unsigned off_cnt;
  // ----------------------------------------
  // Frame length and idle gap counters
  // ----------------------------------------
  // Idle count starts saturated, so the first frame after reset owes no gap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt <= 0;
      off_cnt <= 1000;
    end else begin
      on_cnt <= tx_en ? on_cnt + 1 : 0;
      off_cnt <= tx_en ? 0 : ((off_cnt < 1000) ? off_cnt + 1 : off_cnt);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  ack_follows_a: assert property (req && !ack |=> ack) else $error("ack missing");
  ack_cause_a: assert property (ack |-> $past(req) && !$past(ack)) else $error("ack without request");
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack too long");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request changed early");
  req_drop_a: assert property (ack |=> !req) else $error("request kept after ack");
  rdata_high_a: assert property (ack |-> rdata[15:8] == 8'h00) else $error("read data high byte");
  preamble_start_a: assert property ($rose(tx_en) |-> tx_data ##1 !tx_data ##1 tx_data)
    else $error("preamble order");
  frame_len_a: assert property ($fell(tx_en) |-> on_cnt >= 576 || collision_in) else $error("short frame");
  gap_kept_a: assert property ($rose(tx_en) |-> off_cnt >= 239) else $error("gap too short");
  frame_seen_c: cover property ($fell(tx_en) && !collision_in);
  collided_c: cover property (tx_en && collision_in);
  link_read_c: cover property (ack && !wr);
endmodule : tx_link_assertions

// file: tb/tx_buffer_and_remote_write_tb.sv
// Testbench joining host and device ends, driven over APB.
`timescale 1ns/100ps
`include "tx_defs.svh"
module tx_buffer_and_remote_write_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, collision_in, tx_en, tx_data, en_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] v;
  logic [575:0] fr;
  int fail_count, cmp_count, cyc, flen, nfr;
  tx_link_if link ();
  tx_host tx_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  tx_device tx_device_i (.pclk(pclk), .presetn(presetn), .link(link), .collision_in(collision_in),
    .tx_en(tx_en), .tx_data(tx_data));
  tx_link_assertions tx_link_assertions_i (.pclk(pclk), .presetn(presetn), .req(link.req), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .collision_in(collision_in),
    .tx_en(tx_en), .tx_data(tx_data));
  // ----------------------------------------
  // Clock, serial capture and hang guard
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Sampled on the falling edge, where the registered serial outputs are settled.
  always @(negedge pclk) begin
    if (tx_en === 1'b1 && !en_q) flen = 0;
    if (tx_en === 1'b1) begin
      fr[flen] = tx_data;
      flen++;
    end
    if (tx_en !== 1'b1 && en_q) nfr++;
    en_q = (tx_en === 1'b1);
  end
  // The abort run alone needs some 19200 cycles of backoff and gap.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the idle cycle at the end keeps strobes from being set twice in one step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_idle();
    do apb(1'b0, `APB_STAT, 32'h0000_0000); while (rd[0] !== 1'b0);
  endtask : wait_idle
  task automatic dev_wr(input logic [4:0] a, input logic [15:0] d);
    apb(1'b1, `APB_ADDR, {27'h0, a});
    apb(1'b1, `APB_WDATA, {16'h0, d});
    apb(1'b1, `APB_GO, 32'h0000_0001);
    wait_idle();
  endtask : dev_wr
  task automatic dev_rd(input logic [4:0] a);
    apb(1'b1, `APB_ADDR, {27'h0, a});
    apb(1'b1, `APB_GO, 32'h0000_0000);
    wait_idle();
    apb(1'b0, `APB_RDATA, 32'h0000_0000);
    v = rd[15:0];
  endtask : dev_rd
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_apb();
    apb(1'b0, `APB_STAT, 32'h0000_0000);
    chk({14'h0, rd[1:0]}, 16'h0002);
    apb(1'b1, 12'h020, 32'h0000_0001);
    chk({15'h0, err}, 16'h0001);
  endtask : t_apb
  // Three bytes from the end of page 0x45; the fourth write finds the count spent.
  task automatic t_remote(input logic ring);
    dev_wr(`OFS_RING_EN, {15'h0, ring});
    dev_wr(`OFS_RSTART_H, 16'h0045);
    dev_wr(`OFS_RSTART_L, 16'h00ff);
    dev_wr(`OFS_RCNT_H, 16'h0000);
    dev_wr(`OFS_RCNT_L, 16'h0003);
    repeat (4) dev_wr(`OFS_DATA, 16'h005a);
    dev_rd(`OFS_RCNT_L);
    chk(v, 16'h0000);
    dev_rd(`OFS_RSTART_H);
    chk(v, ring ? 16'h0040 : 16'h0046);
    dev_rd(`OFS_RSTART_L);
    chk(v, 16'h0002);
  endtask : t_remote
  // A collision held on the line makes every attempt fail until the abort.
  task automatic t_abort();
    dev_wr(`OFS_TPAGE, 16'h0040);
    dev_wr(`OFS_TCNT_H, 16'h0000);
    dev_wr(`OFS_TCNT_L, 16'h0010);
    collision_in <= 1'b1;
    dev_wr(`OFS_CMD, 16'h0004);
    do dev_rd(`OFS_CMD); while (v[2] !== 1'b0);
    collision_in <= 1'b0;
    dev_rd(`OFS_TSTAT);
    chk({12'h0, v[3:0]}, 16'h000c);
    dev_rd(`OFS_NCOL);
    chk(v, 16'h0010);
  endtask : t_abort
  task automatic t_tx();
    int k;
    dev_wr(`OFS_WCFG, 16'h0001);
    dev_wr(`OFS_RSTART_H, 16'h0040);
    dev_wr(`OFS_RSTART_L, 16'h0000);
    dev_wr(`OFS_RCNT_H, 16'h0000);
    dev_wr(`OFS_RCNT_L, 16'h0003);
    dev_wr(`OFS_DATA, 16'h3ca5);
    dev_rd(`OFS_RCNT_L);
    chk(v, 16'h0001);
    dev_wr(`OFS_DATA, 16'h0077);
    dev_rd(`OFS_RCNT_L);
    chk(v, 16'h0000);
    dev_wr(`OFS_TPAGE, 16'h0040);
    dev_wr(`OFS_TCNT_H, 16'h0000);
    dev_wr(`OFS_TCNT_L, 16'h0003);
    k = nfr;
    dev_wr(`OFS_CMD, 16'h0004);
    while (nfr == k) @(posedge pclk);
    chk(16'(flen), 16'h0240);
    chk({8'h0, fr[7:0]}, 16'h0055);
    chk(fr[79:64], 16'h3ca5);
    chk(fr[95:80], 16'h0077);
    dev_rd(`OFS_TSTAT);
    chk({12'h0, v[3:0]}, 16'h0001);
    dev_rd(`OFS_TEPR);
    chk(v, 16'h0040);
  endtask : t_tx
  // Five queued entries; the first is hit by a collision and retried, the last is long and unpadded.
  task automatic t_queue();
    int k;
    k = nfr;
    dev_wr(`OFS_QEN, 16'h0001);
    repeat (4) dev_wr(`OFS_CMD, 16'h0004);
    dev_rd(`OFS_TEPR);
    chk(v, 16'h0040);
    dev_wr(`OFS_TCNT_H, 16'h0001);
    dev_wr(`OFS_TCNT_L, 16'h0001);
    dev_wr(`OFS_CMD, 16'h0004);
    dev_rd(`OFS_TEPR);
    chk(v, 16'h00c0);
    while (tx_en !== 1'b1) @(posedge pclk);
    collision_in <= 1'b1;
    repeat (6) @(posedge pclk);
    collision_in <= 1'b0;
    while (nfr != k + 6) @(posedge pclk);
    chk(16'(flen), 16'h0868);
    dev_rd(`OFS_TEPR);
    chk(v, 16'h0041);
    dev_rd(`OFS_NCOL);
    chk(v, 16'h0011);
    dev_rd(`OFS_TSTAT);
    chk({12'h0, v[3:0]}, 16'h0005);
  endtask : t_queue
  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    collision_in = 1'b0;
    en_q = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_apb();
    t_remote(1'b0);
    t_remote(1'b1);
    t_abort();
    t_tx();
    t_queue();
    report_and_stop();
  end
endmodule : tx_buffer_and_remote_write_tb
